//--- inc/sfpio_defines.svh
// constants for the serial frame port of the configurable i/o device
// assumes: included by the package and the core, one 20 MHz clock domain
//
// Summary of operation
// - A frame starts when frame select falls, and the next 16 falling serial clock edges carry input bits.
// - Each of the first 16 falling serial clock edges in a frame shifts the serial input bit into the input shift register.
// - The serial output changes only when frame select falls and on rising serial clock edges, one readback bit per edge, during a frame.
// - When frame select falls, the most significant bit of the outgoing word goes straight onto the serial output.
// - A new output bit is shifted only on the first rising edge after a falling edge while the frame is open.
// - The outgoing word is a sample result, register readback or temperature, chosen by the previous command.
// - Each configurable pin takes one of analog out, analog in, digital in or digital out, as the host configures it.
// - When so configured, the last configurable pin shows busy while a sample conversion runs.
`ifndef SFPIO_DEFINES_SVH
`define SFPIO_DEFINES_SVH

`define SFPIO_WORD_BITS 16
`define SFPIO_CNT_BITS 5
`define SFPIO_PINS 8
`define SFPIO_OUT_RESET 16'h0000
`define SFPIO_CONV_NS 2000
`define SFPIO_CLK_NS 50
`define SFPIO_CONV_CYC ((`SFPIO_CONV_NS + `SFPIO_CLK_NS - 1) / `SFPIO_CLK_NS)

`endif

//--- inc/sfpio_pkg.sv
// types shared by the serial frame port core
// assumes: sfpio_defines.svh is on the include path
`include "sfpio_defines.svh"

package sfpio_pkg;

	typedef enum logic [1:0] {
		SFPIO_FN_AOUT = 2'b00,
		SFPIO_FN_AIN = 2'b01,
		SFPIO_FN_DIN = 2'b10,
		SFPIO_FN_DOUT = 2'b11
	} sfpio_fn_t;

	typedef enum logic [1:0] {
		SFPIO_SRC_SAMPLE = 2'b00,
		SFPIO_SRC_READBACK = 2'b01,
		SFPIO_SRC_TEMP = 2'b10
	} sfpio_src_t;

	typedef enum logic [1:0] {
		SFPIO_ST_IDLE = 2'b00,
		SFPIO_ST_FRAME = 2'b01
	} sfpio_state_t;

	// one completed input frame
	typedef struct packed {
		logic valid;
		logic [`SFPIO_WORD_BITS-1:0] word;
	} sfpio_frame_t;

endpackage : sfpio_pkg

//--- core/sfpio_port.sv
// serial frame port: shifts in 16-bit frames, shifts out a readback word,
// drives per-pin function enables and the busy indication on the last pin.
// assumes: frame select, serial clock and serial input are asynchronous pins;
// the serial clock is slow against clk (400 ns and 700 ns in the bench) and is sampled.
`timescale 1ns/1ps
`include "sfpio_defines.svh"

module sfpio_port (
	input wire logic clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic frame_sel_n,
	input wire logic serial_clk,
	input wire logic serial_in,
	input wire logic [`SFPIO_WORD_BITS-1:0] sample_word,
	input wire logic [`SFPIO_WORD_BITS-1:0] readback_word,
	input wire logic [`SFPIO_WORD_BITS-1:0] temp_word,
	input wire sfpio_pkg::sfpio_src_t out_src,
	input wire logic [2*`SFPIO_PINS-1:0] pin_fn,
	input wire logic busy_mode,
	input wire logic conv_start,
	output logic serial_out,
	output sfpio_pkg::sfpio_frame_t frame_out,
	output logic [`SFPIO_PINS-1:0] aout_en,
	output logic [`SFPIO_PINS-1:0] ain_en,
	output logic [`SFPIO_PINS-1:0] din_en,
	output logic [`SFPIO_PINS-1:0] dout_en,
	output logic config_pin_last_busy
);

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers: first stage read only by the second

	logic [2:0] sync1_reg, sync1_next;
	logic [2:0] sync2_reg, sync2_next;
	logic [1:0] hist_reg, hist_next;

	always_comb begin
		sync1_next = {frame_sel_n, serial_clk, serial_in};
		sync2_next = sync1_reg;
		hist_next = sync2_reg[2:1];
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sync1_reg <= 3'h7;
			sync2_reg <= 3'h7;
			hist_reg <= 2'h3;
		end else if (clk_en) begin
			sync1_reg <= sync1_next;
			sync2_reg <= sync2_next;
			hist_reg <= hist_next;
		end
	end

	logic sel_n_s, sclk_s, sdi_s;
	logic frame_fall, sclk_fall, sclk_rise;
	assign sel_n_s = sync2_reg[2];
	assign sclk_s = sync2_reg[1];
	assign sdi_s = sync2_reg[0];
	assign frame_fall = hist_reg[1] && !sel_n_s;
	assign sclk_fall = hist_reg[0] && !sclk_s;
	assign sclk_rise = !hist_reg[0] && sclk_s;

	function automatic logic [`SFPIO_WORD_BITS-1:0] pick_word(
		input sfpio_pkg::sfpio_src_t src,
		input logic [`SFPIO_WORD_BITS-1:0] s,
		input logic [`SFPIO_WORD_BITS-1:0] r,
		input logic [`SFPIO_WORD_BITS-1:0] t
	);
		case (src)
			sfpio_pkg::SFPIO_SRC_READBACK: pick_word = r;
			sfpio_pkg::SFPIO_SRC_TEMP: pick_word = t;
			default: pick_word = s;
		endcase
	endfunction : pick_word

	////////////////////////////////////////////////////////////////////////
	// frame engine

	sfpio_pkg::sfpio_state_t state_reg, state_next;
	logic [`SFPIO_WORD_BITS-1:0] in_reg, in_next;
	logic [`SFPIO_WORD_BITS-1:0] out_reg, out_next;
	logic [`SFPIO_CNT_BITS-1:0] cnt_reg, cnt_next;
	logic armed_reg, armed_next;
	logic sdo_reg, sdo_next;
	sfpio_pkg::sfpio_frame_t frame_reg, frame_next;

	always_comb begin
		state_next = state_reg;
		in_next = in_reg;
		out_next = out_reg;
		cnt_next = cnt_reg;
		armed_next = armed_reg;
		sdo_next = sdo_reg;
		frame_next = '{valid: 1'b0, word: frame_reg.word};
		case (state_reg)
			sfpio_pkg::SFPIO_ST_IDLE: begin
				// serial clock ignored here
				if (frame_fall) begin
					out_next = pick_word(out_src, sample_word, readback_word,
						temp_word);
					sdo_next = out_next[`SFPIO_WORD_BITS-1];
					cnt_next = '0;
					armed_next = 1'b0;
					state_next = sfpio_pkg::SFPIO_ST_FRAME;
				end
			end
			sfpio_pkg::SFPIO_ST_FRAME: begin
				if (sel_n_s) begin
					state_next = sfpio_pkg::SFPIO_ST_IDLE;
				end else begin
					if (sclk_fall && cnt_reg < 5'h10) begin
						in_next = {in_reg[`SFPIO_WORD_BITS-2:0], sdi_s};
						cnt_next = cnt_reg + 5'h01;
						armed_next = 1'b1;
						if (cnt_reg == 5'h0f) begin
							frame_next = '{valid: 1'b1, word: in_next};
						end
					end
					// idle-low clock: a rise before any fall moves nothing
					if (sclk_rise && armed_reg) begin
						out_next = {out_reg[`SFPIO_WORD_BITS-2:0], 1'b0};
						sdo_next = out_next[`SFPIO_WORD_BITS-1];
						armed_next = 1'b0;
					end
				end
			end
			default: state_next = sfpio_pkg::SFPIO_ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg <= sfpio_pkg::SFPIO_ST_IDLE;
			in_reg <= '0;
			out_reg <= `SFPIO_OUT_RESET;
			cnt_reg <= '0;
			armed_reg <= 1'b0;
			sdo_reg <= 1'b0;
			frame_reg <= '0;
		end else if (clk_en) begin
			state_reg <= state_next;
			in_reg <= in_next;
			out_reg <= out_next;
			cnt_reg <= cnt_next;
			armed_reg <= armed_next;
			sdo_reg <= sdo_next;
			frame_reg <= frame_next;
		end
	end

	assign serial_out = sdo_reg;
	assign frame_out = frame_reg;

	////////////////////////////////////////////////////////////////////////
	// pin functions and busy

	logic [`SFPIO_PINS-1:0] aout_reg, aout_next, ain_reg, ain_next;
	logic [`SFPIO_PINS-1:0] din_reg, din_next, dout_reg, dout_next;
	logic [7:0] conv_reg, conv_next;
	logic busy_reg, busy_next;

	always_comb begin
		for (int i = 0; i < `SFPIO_PINS; i++) begin
			aout_next[i] = pin_fn[2*i +: 2] == sfpio_pkg::SFPIO_FN_AOUT;
			ain_next[i] = pin_fn[2*i +: 2] == sfpio_pkg::SFPIO_FN_AIN;
			din_next[i] = pin_fn[2*i +: 2] == sfpio_pkg::SFPIO_FN_DIN;
			dout_next[i] = pin_fn[2*i +: 2] == sfpio_pkg::SFPIO_FN_DOUT;
		end
		conv_next = conv_reg;
		if (conv_start) begin
			conv_next = 8'(`SFPIO_CONV_CYC);
		end else if (conv_reg != 8'h00) begin
			conv_next = conv_reg - 8'h01;
		end
		busy_next = busy_mode && (conv_next != 8'h00);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			aout_reg <= '0;
			ain_reg <= '0;
			din_reg <= '0;
			dout_reg <= '0;
			conv_reg <= 8'h00;
			busy_reg <= 1'b0;
		end else if (clk_en) begin
			aout_reg <= aout_next;
			ain_reg <= ain_next;
			din_reg <= din_next;
			dout_reg <= dout_next;
			conv_reg <= conv_next;
			busy_reg <= busy_next;
		end
	end

	assign aout_en = aout_reg;
	assign ain_en = ain_reg;
	assign din_en = din_reg;
	assign dout_en = dout_reg;
	assign config_pin_last_busy = busy_reg;

	////////////////////////////////////////////////////////////////////////
	// checks

	sequence s_frame_open;
		clk_en && frame_fall && state_reg == sfpio_pkg::SFPIO_ST_IDLE;
	endsequence

	a_msb_first_out: assert property (@(posedge clk) disable iff (rst)
		s_frame_open |=> serial_out == $past(pick_word(out_src,
			sample_word, readback_word, temp_word)) >> 15)
		else $error("msb not placed at frame start");

	a_no_shift_idle: assert property (@(posedge clk) disable iff (rst)
		clk_en && state_reg == sfpio_pkg::SFPIO_ST_IDLE && !frame_fall |=> $stable(in_reg))
		else $error("shift register moved outside a frame");

	a_rise_unarmed: assert property (@(posedge clk) disable iff (rst)
		clk_en && sclk_rise && !armed_reg && !frame_fall |=> $stable(out_reg))
		else $error("output shifted without a preceding fall");

	a_out_on_rise: assert property (@(posedge clk) disable iff (rst)
		clk_en && !sclk_rise && !frame_fall |=> $stable(serial_out))
		else $error("serial out changed off a rising edge");

	a_frame_done: assert property (@(posedge clk) disable iff (rst)
		clk_en && frame_out.valid |-> $past(cnt_reg) == 5'h0f)
		else $error("frame completed at wrong count");

	a_sample_in: assert property (@(posedge clk) disable iff (rst)
		clk_en && state_reg == sfpio_pkg::SFPIO_ST_FRAME && !sel_n_s && sclk_fall
		&& cnt_reg < 5'h10 |=> in_reg[0] == $past(sdi_s))
		else $error("input bit not sampled on falling edge");

	a_pin_fn: assert property (@(posedge clk) disable iff (rst)
		// reset still seen by the flops at the release edge
		clk_en && !$past(rst) |=> $onehot({aout_en[0], ain_en[0], din_en[0], dout_en[0]}))
		else $error("pin function not exactly one");

	a_busy_conv: assert property (@(posedge clk) disable iff (rst)
		clk_en && conv_start && busy_mode |=> config_pin_last_busy)
		else $error("busy not raised at conversion start");

	a_src_pick: assert property (@(posedge clk) disable iff (rst)
		s_frame_open and out_src == sfpio_pkg::SFPIO_SRC_TEMP
		|=> out_reg == $past(temp_word))
		else $error("wrong outgoing word source");

endmodule : sfpio_port

//--- testbench/sfpio_host.sv
// host model for the serial frame port: frame select, serial clock, data
// assumes: tasks called from tb; half period in clk cycles, at least 4
`timescale 1ns/1ps
module sfpio_host (
	input wire logic clk,
	input wire logic serial_out,
	output logic frame_sel_n,
	output logic serial_clk,
	output logic serial_in
);
	initial begin
		frame_sel_n = 1'b1;
		serial_clk = 1'b1;
		serial_in = 1'b0;
	end
	////////////////////////////////////////////////////////////////////////
	// lo: clock idles low, so a rise comes before the first fall of the frame
	task automatic xfer(input logic [15:0] w, input int half, input int nbits,
		input logic lo, output logic [15:0] rd);
		rd = 16'h0000;
		@(posedge clk);
		serial_clk <= ~lo;
		repeat (4) @(posedge clk);
		frame_sel_n <= 1'b0;
		serial_in <= w[15];
		if (lo) begin
			repeat (half) @(posedge clk);
			serial_clk <= 1'b1;
		end
		for (int i = 0; i < nbits; i++) begin
			repeat (half) @(posedge clk); // 400 ns clock or slower
			rd[15-i] = serial_out;
			serial_clk <= 1'b0;
			repeat (half) @(posedge clk);
			serial_clk <= 1'b1;
			if (i < 15) serial_in <= w[14-i];
		end
		repeat (half) @(posedge clk);
		frame_sel_n <= 1'b1;
		serial_in <= ~serial_in; // released line shows no stale bit
		repeat (4) @(posedge clk);
	endtask : xfer
	// clock activity while deselected
	task automatic idle_toggle(input int n);
		for (int i = 0; i < 2*n; i++) begin
			repeat (4) @(posedge clk);
			serial_clk <= ~serial_clk;
			serial_in <= ~serial_in;
		end
	endtask : idle_toggle
endmodule : sfpio_host

//--- testbench/tb.sv
// testbench of the serial frame port against a host model
// assumes: sfpio_pkg compiled first; 20 MHz clk
`timescale 1ns/1ps
`include "sfpio_defines.svh"
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin bad_count++; \
	$display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module tb;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic frame_sel_n, serial_clk, serial_in, serial_out, config_pin_last_busy;
	logic [15:0] sample_word = 16'h0000, readback_word = 16'h0000, temp_word = 16'h0000;
	sfpio_pkg::sfpio_src_t out_src = sfpio_pkg::SFPIO_SRC_SAMPLE;
	logic [15:0] pin_fn = 16'h0000;
	logic busy_mode = 1'b0;
	logic conv_start = 1'b0;
	logic clk_en = 1'b1;
	sfpio_pkg::sfpio_frame_t frame_out;
	logic [7:0] aout_en, ain_en, din_en, dout_en;
	logic [15:0] got_q[$];
	logic [15:0] rd, w;
	int bad_count = 0;
	int compares = 0;
	integer seed = 32'hcfd17320;
	always #25 clk = ~clk;
	sfpio_port i_dut (.clk(clk), .rst(rst), .clk_en(clk_en), .frame_sel_n(frame_sel_n),
		.serial_clk(serial_clk), .serial_in(serial_in), .sample_word(sample_word),
		.readback_word(readback_word), .temp_word(temp_word), .out_src(out_src),
		.pin_fn(pin_fn), .busy_mode(busy_mode), .conv_start(conv_start),
		.serial_out(serial_out), .frame_out(frame_out), .aout_en(aout_en),
		.ain_en(ain_en), .din_en(din_en), .dout_en(dout_en),
		.config_pin_last_busy(config_pin_last_busy));
	sfpio_host i_host (.clk(clk), .serial_out(serial_out), .frame_sel_n(frame_sel_n),
		.serial_clk(serial_clk), .serial_in(serial_in));
	always @(posedge clk) if (frame_out.valid === 1'b1) got_q.push_back(frame_out.word);
	////////////////////////////////////////////////////////////////////////
	task automatic report_and_stop;
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : report_and_stop
	task automatic chk_pins(input logic [15:0] pf);
		logic [1:0] fn;
		logic [3:0] ef, gf;
		for (int p = 0; p < 8; p++) begin
			fn = pf[2*p +: 2];
			ef = {fn == 2'd3, fn == 2'd2, fn == 2'd1, fn == 2'd0};
			gf = {dout_en[p], din_en[p], ain_en[p], aout_en[p]};
			`CHK("pin fn", ef, gf)
		end
	endtask : chk_pins
	task automatic run_frame(input logic [1:0] src, input int half, input logic lo);
		logic [15:0] ex;
		@(posedge clk);
		sample_word <= 16'($random(seed));
		readback_word <= 16'($random(seed));
		temp_word <= 16'($random(seed));
		out_src <= sfpio_pkg::sfpio_src_t'(src);
		@(posedge clk);
		ex = (src == 2'd1) ? readback_word : (src == 2'd2) ? temp_word : sample_word;
		w = 16'($random(seed));
		i_host.xfer(w, half, 16, lo, rd);
		`CHK("readback", ex, rd)
		`CHK("frames", 1, got_q.size())
		`CHK("word", w, got_q[0])
		got_q.delete();
		$display("frame src %0d done", src);
	endtask : run_frame
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		repeat (6) @(posedge clk);
		for (int s = 0; s < 4; s++) run_frame(s[1:0], 4, s[0]);
		run_frame(2'd1, 7, 1'b0);
		// deselected clocking and a cut-short frame yield no word
		i_host.idle_toggle(6);
		i_host.xfer(16'ha5a5, 4, 9, 1'b1, rd);
		`CHK("no word", 0, got_q.size())
		$display("ignore test done");
		for (int k = 0; k < 6; k++) begin
			@(posedge clk);
			pin_fn <= 16'($random(seed));
			repeat (3) @(posedge clk);
			chk_pins(pin_fn);
		end
		// enable low: the decode must keep the old functions
		@(posedge clk);
		clk_en <= 1'b0;
		pin_fn <= ~pin_fn;
		repeat (3) @(posedge clk);
		chk_pins(~pin_fn);
		clk_en <= 1'b1;
		$display("pin function test done");
		for (int m = 0; m < 2; m++) begin
			@(posedge clk);
			busy_mode <= m[0];
			conv_start <= 1'b1;
			@(posedge clk);
			conv_start <= 1'b0;
			repeat (3) @(posedge clk);
			`CHK("busy", m[0], config_pin_last_busy)
			repeat (`SFPIO_CONV_CYC - 3) @(posedge clk);
			`CHK("busy last", m[0], config_pin_last_busy)
			@(posedge clk);
			`CHK("busy end", 1'b0, config_pin_last_busy)
		end
		$display("busy test done");
		report_and_stop();
	end
	initial begin
		#1000000;
		bad_count++;
		$display("watchdog expired");
		report_and_stop();
	end
endmodule : tb
